// ===== rtl/imrc_pkg.sv
// constants and types of the two-wire mode and rate control block
package imrc_pkg;

    // ==================================================
    // register map, byte addresses
    localparam int APB_ADDR_W = 12;
    localparam logic [11:0] ADDR_CONTROL_ONE = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_OWN_ADDRESS = 12'h00c;
    localparam logic [11:0] ADDR_RECEIVE_DATA = 12'h010;
    localparam logic [11:0] ADDR_FORMAT = 12'h014;

    // ==================================================
    // control register fields and reset values
    localparam int BIT_INTERFACE_ENABLE = 7;
    localparam int BIT_RECEPTION_DISABLE = 6;
    localparam int BIT_MASTER_SELECT = 5;
    localparam int BIT_DIRECTION_SELECT = 4;
    localparam int BIT_RATE_TOP = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [6:0] OWN_ADDRESS_RESET = 7'h00;
    localparam logic FORMAT_RESET = 1'h0;

    // ==================================================
    // status bits, shared by the mask register
    localparam int STATUS_W = 4;
    localparam int ST_ARB_LOST = 0;
    localparam int ST_ADDR_MATCH = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_SETUP_DONE = 3;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 4'h0;

    // ==================================================
    // slave transmit setup time in system clock cycles
    localparam int SETUP_W = 5;
    localparam logic [SETUP_W-1:0] SETUP_SHORT_CYCLES = 5'h0a;
    localparam logic [SETUP_W-1:0] SETUP_LONG_CYCLES = 5'h14;

    // ==================================================
    // modes and states
    typedef enum logic [1:0] {
        MODE_SLAVE_RX = 2'h0,
        MODE_SLAVE_TX = 2'h1,
        MODE_MASTER_RX = 2'h2,
        MODE_MASTER_TX = 2'h3
    } imrc_mode_t;

    typedef enum logic [1:0] {
        SETUP_IDLE = 2'h1,
        SETUP_WAIT = 2'h2
    } imrc_setup_state_t;

    // ==================================================
    // bit period divisors
    localparam int DIV_W = 9;

    function automatic logic [DIV_W-1:0] imrc_divisor(input logic [3:0] sel);
        logic [DIV_W-1:0] d;
        d = 9'h01c;
        case (sel)
            4'h0: d = 9'h01c;
            4'h1: d = 9'h028;
            4'h2: d = 9'h030;
            4'h3: d = 9'h040;
            4'h4: d = 9'h050;
            4'h5: d = 9'h064;
            4'h6: d = 9'h070;
            4'h7: d = 9'h080;
            4'h8: d = 9'h038;
            4'h9: d = 9'h050;
            4'ha: d = 9'h060;
            4'hb: d = 9'h080;
            4'hc: d = 9'h0a0;
            4'hd: d = 9'h0c8;
            4'he: d = 9'h0e0;
            4'hf: d = 9'h100;
            default: d = 9'h01c;
        endcase
        return d;
    endfunction

endpackage

// ===== rtl/imrc_rate_if.sv
// carrier between the control logic and the bit period divider
`timescale 1ns/1ps
`default_nettype none
interface imrc_rate_if;
    import imrc_pkg::*;
    logic enable;
    logic [DIV_W-1:0] divisor;
    logic tick;
    logic scl_level;
    modport ctrl (output enable, output divisor, input tick, input scl_level);
    modport gen (input enable, input divisor, output tick, output scl_level);
endinterface
`default_nettype wire

// ===== rtl/imrc_divider.sv
// bit period divider producing the master serial clock
`timescale 1ns/1ps
`default_nettype none
module imrc_divider
    import imrc_pkg::*;
(
    // clock and synchronised reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // rate carrier
    imrc_rate_if.gen rate
);

    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic scl_level;
    } imrc_div_state_t;

    imrc_div_state_t state_reg;
    imrc_div_state_t state_next;
    logic terminal;
    logic [DIV_W-1:0] last_count;
    logic [DIV_W-1:0] half_count;

    assign last_count = rate.divisor - 9'h001;
    assign half_count = {1'b0, rate.divisor[DIV_W-1:1]} - 9'h001;
    assign terminal = rate.enable && (state_reg.count >= last_count);
    assign rate.tick = terminal;
    assign rate.scl_level = state_reg.scl_level;

    // ==================================================
    // counter restarts every bit period, low half then high half
    always_comb
    begin
        state_next = state_reg;
        if (!rate.enable)
        begin
            state_next.count = '0;
            state_next.scl_level = 1'b1;
        end
        else if (terminal)
        begin
            state_next.count = '0;
            state_next.scl_level = 1'b0;
        end
        else
        begin
            state_next.count = state_reg.count + 9'h001;
            if (state_reg.count == half_count)
            begin
                state_next.scl_level = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '{count: '0, scl_level: 1'b1};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==================================================
    // gap between ticks while the divisor stands still
    logic [DIV_W-1:0] gap_cnt;
    logic gap_valid;
    logic [DIV_W-1:0] div_seen;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gap_cnt <= '0;
            gap_valid <= 1'b0;
            div_seen <= '0;
        end
        else
        begin
            div_seen <= rate.divisor;
            if (!rate.enable || (rate.divisor != div_seen))
            begin
                gap_cnt <= '0;
                gap_valid <= 1'b0;
            end
            else if (rate.tick)
            begin
                gap_cnt <= '0;
                gap_valid <= 1'b1;
            end
            else
            begin
                gap_cnt <= gap_cnt + 9'h001;
            end
        end
    end

    chk_period_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (rate.tick && gap_valid && rate.divisor == div_seen) |-> (gap_cnt == last_count))
        else $error("bit period differs from selected divisor");

    chk_idle_high: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!rate.enable) |=> (rate.scl_level && !rate.tick))
        else $error("divider not idle while disabled");

endmodule // imrc_divider
`default_nettype wire

// ===== rtl/imrc_top.sv
// mode, direction and rate control of the two-wire serial interface
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module imrc_top
    import imrc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // events from the transfer engine
    input wire logic i_arb_lost,
    input wire logic i_overrun,
    input wire logic i_addr_valid,
    input wire logic [7:0] i_addr_byte,
    input wire logic [7:0] i_rx_data,
    input wire logic i_setup_start,
    // mode and timing to the transfer engine
    output logic o_pins_bus,
    output imrc_mode_t o_mode,
    output logic o_sync_format,
    output logic o_rx_start,
    output logic o_bit_tick,
    output logic o_setup_busy,
    output logic o_setup_done,
    // serial clock pin
    output logic o_scl_o,
    output logic o_scl_oe,
    // interrupt
    output logic o_irq
);

    // ==================================================
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==================================================
    // state
    typedef struct packed {
        logic [7:0] control;
        logic [STATUS_W-1:0] status;
        logic [STATUS_W-1:0] mask;
        logic [6:0] own_addr;
        logic sync_format;
        logic [31:0] prdata;
        logic pslverr;
        logic rx_start;
        imrc_setup_state_t setup_state;
        logic [SETUP_W-1:0] setup_count;
    } imrc_state_t;

    localparam imrc_state_t STATE_RESET = '{
        control: CONTROL_RESET,
        status: STATUS_RESET,
        mask: STATUS_RESET,
        own_addr: OWN_ADDRESS_RESET,
        sync_format: FORMAT_RESET,
        prdata: 32'h00000000,
        pslverr: 1'b0,
        rx_start: 1'b0,
        setup_state: SETUP_IDLE,
        setup_count: '0
    };

    imrc_state_t state_reg;
    imrc_state_t state_next;

    imrc_rate_if rate ();

    logic interface_enable;
    logic reception_disable;
    logic master_select;
    logic direction_select;
    logic setup_phase;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic arb_event;
    logic match_event;
    logic overrun_event;
    logic setup_done;
    logic [STATUS_W-1:0] events;
    logic [STATUS_W-1:0] clear_bits;

    assign interface_enable = state_reg.control[BIT_INTERFACE_ENABLE];
    assign reception_disable = state_reg.control[BIT_RECEPTION_DISABLE];
    assign master_select = state_reg.control[BIT_MASTER_SELECT];
    assign direction_select = state_reg.control[BIT_DIRECTION_SELECT];

    assign setup_phase = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    assign rd = access && !i_pwrite;
    assign mapped = (i_paddr == ADDR_CONTROL_ONE) || (i_paddr == ADDR_STATUS)
        || (i_paddr == ADDR_MASK) || (i_paddr == ADDR_OWN_ADDRESS)
        || (i_paddr == ADDR_RECEIVE_DATA) || (i_paddr == ADDR_FORMAT);

    // ==================================================
    // hardware mode events
    assign arb_event = i_arb_lost && interface_enable && master_select && !state_reg.sync_format;
    assign overrun_event = i_overrun && interface_enable && master_select && state_reg.sync_format;
    assign match_event = i_addr_valid && interface_enable && !master_select && !direction_select
        && (i_addr_byte[7:1] == state_reg.own_addr) && i_addr_byte[0];
    assign setup_done = (state_reg.setup_state == SETUP_WAIT)
        && (state_reg.setup_count == '0);

    always_comb
    begin
        events = '0;
        events[ST_ARB_LOST] = arb_event;
        events[ST_ADDR_MATCH] = match_event;
        events[ST_OVERRUN] = overrun_event;
        events[ST_SETUP_DONE] = setup_done;
    end

    assign clear_bits = (wr && i_paddr == ADDR_STATUS) ? i_pwdata[STATUS_W-1:0] : '0;

    // ==================================================
    // next state
    always_comb
    begin
        state_next = state_reg;
        state_next.rx_start = 1'b0;

        // read data captured in the setup phase
        if (setup_phase)
        begin
            state_next.prdata = 32'h00000000;
            state_next.pslverr = !mapped;
            case (i_paddr)
                ADDR_CONTROL_ONE: state_next.prdata[7:0] = state_reg.control;
                ADDR_STATUS: state_next.prdata[STATUS_W-1:0] = state_reg.status;
                ADDR_MASK: state_next.prdata[STATUS_W-1:0] = state_reg.mask;
                ADDR_OWN_ADDRESS: state_next.prdata[6:0] = state_reg.own_addr;
                ADDR_RECEIVE_DATA: state_next.prdata[7:0] = i_rx_data;
                ADDR_FORMAT: state_next.prdata[0] = state_reg.sync_format;
                default: state_next.prdata = 32'h00000000;
            endcase
        end

        // software writes
        if (wr)
        begin
            case (i_paddr)
                ADDR_CONTROL_ONE: state_next.control = i_pwdata[7:0];
                ADDR_MASK: state_next.mask = i_pwdata[STATUS_W-1:0];
                ADDR_OWN_ADDRESS: state_next.own_addr = i_pwdata[6:0];
                ADDR_FORMAT: state_next.sync_format = i_pwdata[0];
                default: state_next.mask = state_next.mask;
            endcase
        end

        // hardware mode changes win over a write in the same cycle
        if (arb_event)
        begin
            state_next.control[BIT_MASTER_SELECT] = 1'b0;
            state_next.control[BIT_DIRECTION_SELECT] = 1'b0;
        end
        if (overrun_event)
        begin
            state_next.control[BIT_MASTER_SELECT] = 1'b0;
        end
        if (match_event)
        begin
            state_next.control[BIT_DIRECTION_SELECT] = 1'b1;
        end

        // next reception after a receive data read
        if (rd && i_paddr == ADDR_RECEIVE_DATA && interface_enable && !direction_select && !reception_disable)
        begin
            state_next.rx_start = 1'b1;
        end

        // sticky status, set wins over clear
        state_next.status = (state_reg.status & ~clear_bits) | events;

        // slave transmit setup time
        case (state_reg.setup_state)
            SETUP_IDLE:
            begin
                if (i_setup_start && interface_enable && !master_select)
                begin
                    state_next.setup_state = SETUP_WAIT;
                    state_next.setup_count = state_reg.control[BIT_RATE_TOP]
                        ? SETUP_LONG_CYCLES - 5'h01 : SETUP_SHORT_CYCLES - 5'h01;
                end
            end
            SETUP_WAIT:
            begin
                if (setup_done)
                begin
                    state_next.setup_state = SETUP_IDLE;
                end
                else
                begin
                    state_next.setup_count = state_reg.setup_count - 5'h01;
                end
            end
            default: state_next.setup_state = SETUP_IDLE;
        endcase

        if (!interface_enable)
        begin
            state_next.setup_state = SETUP_IDLE;
            state_next.setup_count = '0;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==================================================
    // bit rate divider, master only
    assign rate.enable = interface_enable && master_select;
    assign rate.divisor = imrc_divisor(state_reg.control[3:0]);

    imrc_divider u_divider (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .rate(rate)
    );

    // ==================================================
    // outputs
    assign o_prdata = state_reg.prdata;
    assign o_pready = access;
    assign o_pslverr = access && state_reg.pslverr;
    assign o_pins_bus = interface_enable;
    assign o_mode = imrc_mode_t'({master_select, direction_select});
    assign o_sync_format = state_reg.sync_format;
    assign o_rx_start = state_reg.rx_start;
    assign o_bit_tick = rate.tick;
    assign o_setup_busy = (state_reg.setup_state == SETUP_WAIT);
    assign o_setup_done = setup_done;
    assign o_scl_o = rate.scl_level;
    // push-pull clock in synchronous format, open-drain low otherwise
    assign o_scl_oe = interface_enable && master_select && (state_reg.sync_format || !rate.scl_level);
    assign o_irq = |(state_reg.status & state_reg.mask);

    // ==================================================
    // checks
    chk_enable_release: assert property (@(posedge i_clock) disable iff (!rst_n)
        (!interface_enable) |-> (!o_pins_bus && !o_scl_oe && !o_bit_tick))
        else $error("pins not released while interface disabled");

    chk_rx_restart: assert property (@(posedge i_clock) disable iff (!rst_n)
        (rd && i_paddr == ADDR_RECEIVE_DATA && interface_enable && !direction_select) |=> (o_rx_start == !$past(reception_disable)))
        else $error("next reception start wrong after receive data read");

    chk_mode_decode: assert property (@(posedge i_clock) disable iff (!rst_n)
        (o_mode == MODE_MASTER_TX) |-> (o_scl_oe || !interface_enable || !state_reg.sync_format))
        else $error("master transmit decode does not drive clock");

    chk_arb_clear: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_arb_lost && interface_enable && master_select && !state_reg.sync_format)
        |=> (o_mode == MODE_SLAVE_RX && state_reg.status[ST_ARB_LOST]))
        else $error("arbitration loss did not force slave receive");

    chk_addr_match: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_addr_valid && interface_enable && o_mode == MODE_SLAVE_RX
        && i_addr_byte[7:1] == state_reg.own_addr && i_addr_byte[0])
        |=> (o_mode == MODE_SLAVE_TX && state_reg.status[ST_ADDR_MATCH]))
        else $error("address match did not select slave transmit");

    chk_overrun_clear: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_overrun && interface_enable && master_select && state_reg.sync_format) |=> (!master_select && !o_scl_oe))
        else $error("overrun did not clear master select");

    chk_sync_clock: assert property (@(posedge i_clock) disable iff (!rst_n)
        (state_reg.sync_format && interface_enable) |-> (o_scl_oe == master_select))
        else $error("synchronous clock drive not tied to master select");

    chk_setup_short: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_setup_start && interface_enable && !master_select && !o_setup_busy && !state_reg.control[BIT_RATE_TOP])
        |-> ##1 (!o_setup_done)[*8] ##2 (o_setup_done || !interface_enable))
        else $error("short setup time not ten cycles");

    chk_setup_long: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_setup_start && interface_enable && !master_select && !o_setup_busy && state_reg.control[BIT_RATE_TOP])
        |-> ##1 (!o_setup_done)[*8] ##12 (o_setup_done || !interface_enable))
        else $error("long setup time not twenty cycles");

    chk_status_sticky: assert property (@(posedge i_clock) disable iff (!rst_n)
        (state_reg.status[ST_ARB_LOST] && !(wr && i_paddr == ADDR_STATUS
        && i_pwdata[ST_ARB_LOST])) |=> state_reg.status[ST_ARB_LOST])
        else $error("arbitration loss flag not sticky");

    chk_slave_quiet: assert property (@(posedge i_clock) disable iff (!rst_n)
        (!master_select) |-> (!o_bit_tick && !o_scl_oe))
        else $error("divider running outside master mode");

    chk_setup_abort: assert property (@(posedge i_clock) disable iff (!rst_n)
        (!interface_enable) |=> (!o_setup_busy))
        else $error("setup timer not stopped while disabled");

    chk_rx_idle: assert property (@(posedge i_clock) disable iff (!rst_n)
        reception_disable |=> (!o_rx_start))
        else $error("reception started although disabled");

endmodule // imrc_top
`default_nettype wire

// ===== bench/imrc_partner.sv
// model of the transfer engine and far bus side raising events
`timescale 1ns/1ps
`default_nettype none
module imrc_partner
(
    // clock
    input wire logic i_clock,
    // events towards the block
    output logic o_arb_lost,
    output logic o_overrun,
    output logic o_addr_valid,
    output logic [7:0] o_addr_byte,
    output logic [7:0] o_rx_data,
    output logic o_setup_start
);
    // ==================================================
    // idle levels
    initial
    begin
        o_arb_lost = 1'b0;
        o_overrun = 1'b0;
        o_addr_valid = 1'b0;
        o_addr_byte = 8'h00;
        o_rx_data = 8'h3c;
        o_setup_start = 1'b0;
    end

    // ==================================================
    // one-cycle event: 0 loss, 1 overrun, 2 setup start, 3 first byte
    task automatic pulse(input int kind, input logic [7:0] b);
        @(posedge i_clock);
        o_arb_lost <= (kind == 0);
        o_overrun <= (kind == 1);
        o_setup_start <= (kind == 2);
        o_addr_valid <= (kind == 3);
        o_addr_byte <= b;
        @(posedge i_clock);
        o_arb_lost <= 1'b0;
        o_overrun <= 1'b0;
        o_setup_start <= 1'b0;
        o_addr_valid <= 1'b0;
        // byte lines are not held once valid drops
        o_addr_byte <= ~b;
    endtask
endmodule // imrc_partner
`default_nettype wire

// ===== bench/imrc_top_tb.sv
// self-checking bench of the two-wire mode and rate control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", what, (exp), (got)); end end
module imrc_top_tb;
    import imrc_pkg::*;
    typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic x;} imrc_row_t;
    localparam int LIMIT = 20000;
    int bad_count = 0, checked = 0, cycles = 0, n, k;
    logic i_clock = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd, o_prdata;
    logic err, o_pready, o_pslverr, o_pins_bus, o_sync_format, o_rx_start, o_bit_tick;
    logic o_setup_busy, o_setup_done, o_scl_o, o_scl_oe, o_irq;
    logic i_arb_lost, i_overrun, i_addr_valid, i_setup_start;
    logic [7:0] i_addr_byte, i_rx_data;
    imrc_mode_t o_mode;
    imrc_row_t rows [6];
    logic [31:0] ctl [3] = '{32'h80, 32'hc0, 32'h90};
    int divs [16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};

    always #50 i_clock = ~i_clock;

    imrc_top imrc_top_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_arb_lost(i_arb_lost), .i_overrun(i_overrun), .i_addr_valid(i_addr_valid),
        .i_addr_byte(i_addr_byte), .i_rx_data(i_rx_data), .i_setup_start(i_setup_start),
        .o_pins_bus(o_pins_bus), .o_mode(o_mode), .o_sync_format(o_sync_format),
        .o_rx_start(o_rx_start), .o_bit_tick(o_bit_tick), .o_setup_busy(o_setup_busy),
        .o_setup_done(o_setup_done), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .o_irq(o_irq));

    imrc_partner imrc_partner_i (.i_clock(i_clock), .o_arb_lost(i_arb_lost),
        .o_overrun(i_overrun), .o_addr_valid(i_addr_valid), .o_addr_byte(i_addr_byte),
        .o_rx_data(i_rx_data), .o_setup_start(i_setup_start));

    // ==================================================
    // bus master and helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do
            @(posedge i_clock);
        while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
        #1;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rd, err);
        `CHK("register read", e, rd)
    endtask

    task automatic settle();
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    task automatic wait_tick(output int c);
        for (c = 1; c < 600; c++)
        begin
            @(negedge i_clock);
            if (o_bit_tick === 1'b1)
                break;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            bad_count++;
            end_of_test();
        end
    end

    // ==================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge i_clock);
        `CHK("clock level in reset", 1'b1, o_scl_o)
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clock);
        for (n = 0; n < 24; n += 4)
            if (n != 16)
                rd_chk(12'(n), 32'h0);
        $display("test reset done");
        rows[0] = {ADDR_OWN_ADDRESS, 32'hffffffff, 32'h7f, 1'b0};
        rows[1] = {ADDR_MASK, 32'hff, 32'hf, 1'b0};
        rows[2] = {ADDR_FORMAT, 32'hff, 32'h1, 1'b0};
        rows[3] = {ADDR_CONTROL_ONE, 32'h15a, 32'h5a, 1'b0};
        rows[4] = {ADDR_RECEIVE_DATA, 32'hff, 32'h3c, 1'b0};
        rows[5] = {12'h018, 32'hff, 32'h0, 1'b1};
        foreach (rows[r])
        begin
            apb(1'b1, rows[r].a, rows[r].w, rd, err);
            apb(1'b0, rows[r].a, 32'h0, rd, err);
            `CHK("row read data", rows[r].e, rd)
            `CHK("row error flag", rows[r].x, err)
        end
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_FORMAT, 32'h0);
        $display("test rows done");
        for (n = 0; n < 4; n++)
        begin
            wr(ADDR_CONTROL_ONE, 32'h80 | (n << 4));
            `CHK("mode", 2'(n), o_mode)
            `CHK("pins claimed", 1'b1, o_pins_bus)
        end
        wr(ADDR_CONTROL_ONE, 32'h30);
        `CHK("pins released", 1'b0, o_pins_bus)
        `CHK("clock released", 1'b0, o_scl_oe)
        wr(ADDR_FORMAT, 32'h1);
        `CHK("format bit", 1'b1, o_sync_format)
        wr(ADDR_CONTROL_ONE, 32'h80);
        for (n = 0; n < 60; n++)
        begin
            @(negedge i_clock);
            `CHK("clock drive as slave", 1'b0, o_scl_oe)
        end
        wr(ADDR_CONTROL_ONE, 32'ha0);
        `CHK("clock drive as master", 1'b1, o_scl_oe)
        $display("test modes done");
        imrc_partner_i.pulse(0, 8'h00);
        settle();
        `CHK("loss ignored in sync format", MODE_MASTER_RX, o_mode)
        imrc_partner_i.pulse(1, 8'h00);
        settle();
        `CHK("mode after overrun", MODE_SLAVE_RX, o_mode)
        wr(ADDR_FORMAT, 32'h0);
        wr(ADDR_CONTROL_ONE, 32'hb0);
        imrc_partner_i.pulse(1, 8'h00);
        settle();
        `CHK("overrun ignored in two-wire", MODE_MASTER_TX, o_mode)
        imrc_partner_i.pulse(0, 8'h00);
        settle();
        `CHK("mode after loss", MODE_SLAVE_RX, o_mode)
        `CHK("irq masked", 1'b0, o_irq)
        wr(ADDR_MASK, 32'h1);
        settle();
        `CHK("irq raised", 1'b1, o_irq)
        wr(ADDR_STATUS, 32'h1);
        settle();
        `CHK("irq cleared", 1'b0, o_irq)
        rd_chk(ADDR_STATUS, 32'h4);
        wr(ADDR_STATUS, 32'h4);
        $display("test events done");
        wr(ADDR_OWN_ADDRESS, 32'h35);
        wr(ADDR_CONTROL_ONE, 32'h80);
        imrc_partner_i.pulse(3, 8'h6a);
        imrc_partner_i.pulse(3, 8'h69);
        settle();
        `CHK("direction without match", MODE_SLAVE_RX, o_mode)
        imrc_partner_i.pulse(3, 8'h6b);
        settle();
        `CHK("direction on match", MODE_SLAVE_TX, o_mode)
        rd_chk(ADDR_STATUS, 32'h2);
        wr(ADDR_CONTROL_ONE, 32'h80);
        `CHK("direction back", MODE_SLAVE_RX, o_mode)
        for (n = 0; n < 3; n++)
        begin
            wr(ADDR_CONTROL_ONE, ctl[n]);
            apb(1'b0, ADDR_RECEIVE_DATA, 32'h0, rd, err);
            #1;
            `CHK("reception start", n == 0, o_rx_start)
        end
        $display("test address and reception done");
        for (n = 0; n < 2; n++)
        begin
            wr(ADDR_CONTROL_ONE, 32'h80 | (n << 3));
            imrc_partner_i.pulse(2, 8'h00);
            for (k = 1; k < 40; k++)
            begin
                @(negedge i_clock);
                if (o_setup_done === 1'b1)
                    break;
            end
            `CHK("setup time", (n == 1) ? 20 : 10, k)
            `CHK("setup busy at done", 1'b1, o_setup_busy)
        end
        for (n = 0; n < 16; n++)
        begin
            wr(ADDR_CONTROL_ONE, 32'ha0 | n);
            wait_tick(k);
            wait_tick(k);
            `CHK("bit period", divs[n], k)
        end
        $display("test timing done");
        end_of_test();
    end
endmodule // imrc_top_tb
`default_nettype wire
